// ### design/fail_safe_clock_pkg.sv
// Constants, encodings and carriers for the fail-safe clock source control block
package fail_safe_clock_pkg;
  // Register indexes; the byte address is four times the index
  localparam logic [7:0] OSC_CTRL_IDX = 8'h8F;
  localparam logic [7:0] OSC_TUNE_IDX = 8'h90;
  localparam logic [7:0] OSC_CFG_IDX = 8'h91;
  localparam logic [7:0] FAIL_FLAG_IDX = 8'h92;
  localparam logic [7:0] FAIL_IE_IDX = 8'h93;
  localparam logic [11:0] OSC_CTRL_ADDR = {2'h0, OSC_CTRL_IDX, 2'h0};
  localparam logic [11:0] OSC_TUNE_ADDR = {2'h0, OSC_TUNE_IDX, 2'h0};
  localparam logic [11:0] OSC_CFG_ADDR = {2'h0, OSC_CFG_IDX, 2'h0};
  localparam logic [11:0] FAIL_FLAG_ADDR = {2'h0, FAIL_FLAG_IDX, 2'h0};
  localparam logic [11:0] FAIL_IE_ADDR = {2'h0, FAIL_IE_IDX, 2'h0};

  // Field positions
  localparam int FREQ_LSB = 4;
  localparam int START_UP_TIMEOUT_STATUS_BIT = 3;
  localparam int HTS_BIT = 2;
  localparam int LTS_BIT = 1;
  localparam int SCS_BIT = 0;
  localparam int TUNE_LSB = 0;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_TWO_SPEED_BIT = 3;
  localparam int CFG_MON_EN_BIT = 4;
  localparam int FAIL_FLAG_BIT = 7;
  localparam int FAIL_ACTIVE_BIT = 0;
  localparam int FAIL_IE_BIT = 7;

  // Values after reset
  localparam logic [2:0] FREQ_RST = 3'h6;
  localparam logic SCS_RST = 1'h0;
  localparam logic [4:0] TUNE_RST = 5'h00;
  localparam logic [2:0] CFG_MODE_RST = 3'h1;
  localparam logic CFG_TWO_SPEED_RST = 1'h0;
  localparam logic CFG_MON_EN_RST = 1'h0;
  localparam logic FAIL_IE_RST = 1'h0;

  // Cycle counts, in edges of the oscillator being counted
  localparam int OST_COUNT = 1024;
  localparam int SAMPLE_DIV = 64;
  localparam logic [10:0] OST_LAST = 11'(OST_COUNT - 1);
  localparam logic [5:0] DIV_LAST = 6'(SAMPLE_DIV - 1);

  typedef enum logic [2:0] {
    MODE_LP = 3'b000,
    MODE_XT = 3'b001,
    MODE_HS = 3'b010,
    MODE_EC = 3'b011,
    MODE_RC = 3'b100,
    MODE_RCIO = 3'b101
  } osc_mode_e;

  typedef enum logic [1:0] {
    ST_START = 2'b00,
    ST_EXT = 2'b01,
    ST_FAIL = 2'b10,
    ST_SLEEP = 2'b11
  } clk_state_e;

  typedef struct packed {
    logic monEn;
    logic twoSpeedEn;
    logic [2:0] mode;
  } osc_cfg_s;

  typedef struct packed {
    logic runInternal;
    logic cpuHold;
    logic [2:0] freqSel;
    logic [4:0] tune;
  } clk_ctrl_s;
endpackage

// ### design/fail_safe_clock_control.sv
// Clock source selection, start-up timer and fail-safe monitor with APB registers
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module fail_safe_clock_control (
  input wire logic core_clk, // 125 MHz core clock
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic extClk, // External oscillator level
  input wire logic lfClk, // Low-frequency internal oscillator level
  input wire logic hfStable, // High-frequency internal oscillator stable
  input wire logic lfStable, // Low-frequency internal oscillator stable
  input wire logic sleepEnter, // Sleep instruction executed, pulse
  input wire logic wakeUp, // Wake-up from sleep, pulse
  output fail_safe_clock_pkg::clk_ctrl_s clkCtrl, // Clock mux control
  output logic failSafeActive, // Fail-safe condition in force
  output logic oscFailIrq // Oscillator fail interrupt request
);
  import fail_safe_clock_pkg::*;

  clk_state_e state_q, state_d;
  logic [10:0] ostCnt_q, ostCnt_d;
  logic [5:0] divCnt_q, divCnt_d;
  logic failLatch_q, failLatch_d;
  logic extPrev_q, lfPrev_q;
  logic scs_q, scs_d;
  logic [2:0] freq_q, freq_d;
  logic [4:0] tune_q, tune_d;
  osc_cfg_s cfg_q, cfg_d;
  logic flag_q, flag_d;
  logic ie_q, ie_d;
  clk_ctrl_s ctrl_q, ctrl_d;
  logic [31:0] rdData_q, rdData_d;
  logic extFall, lfFall, sampleTick, failDet, ostDone;
  logic wrEn, wrCtrl, scsToggle, crystal, twoSpeed, addrHit, start_up_timeout_status;
  logic [7:0] ctrlRead;

  // Inputs are synchronous, so one delay flop is enough for edge detection
  assign extFall = extPrev_q & ~extClk;
  assign lfFall = lfPrev_q & ~lfClk;
  assign sampleTick = lfFall && (divCnt_q == DIV_LAST);
  assign crystal = (cfg_q.mode == MODE_LP) || (cfg_q.mode == MODE_XT) || (cfg_q.mode == MODE_HS);
  assign twoSpeed = cfg_q.twoSpeedEn | cfg_q.monEn;
  assign ostDone = (state_q == ST_START) && crystal && extFall && (ostCnt_q == OST_LAST);
  // Detection only in the ST_EXT state, whatever the select bit; start-up never trips it
  assign failDet = cfg_q.monEn && (state_q == ST_EXT) && sampleTick
    && !failLatch_q && !extFall;
  assign wrEn = psel && penable && pwrite;
  assign wrCtrl = wrEn && (paddr == OSC_CTRL_ADDR);
  assign scsToggle = wrCtrl && (pwdata[SCS_BIT] != scs_q);
  assign start_up_timeout_status = (state_q == ST_EXT) && !scs_q;
  assign addrHit = (paddr == OSC_CTRL_ADDR) || (paddr == OSC_TUNE_ADDR)
    || (paddr == OSC_CFG_ADDR) || (paddr == FAIL_FLAG_ADDR) || (paddr == FAIL_IE_ADDR);
  assign ctrlRead = {1'b0, freq_q, start_up_timeout_status, hfStable, lfStable, scs_q};

  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrHit;
  assign prdata = rdData_q;
  assign clkCtrl = ctrl_q;
  assign failSafeActive = (state_q == ST_FAIL);
  assign oscFailIrq = flag_q & ie_q;

  always_comb
  begin
    state_d = state_q;
    ostCnt_d = ostCnt_q;
    case (state_q)
      ST_START:
      begin
        if (!crystal)
        begin
          state_d = ST_EXT;
          ostCnt_d = 11'h000;
        end
        else if (extFall)
        begin
          if (ostCnt_q == OST_LAST)
          begin
            state_d = ST_EXT;
            ostCnt_d = 11'h000;
          end
          else
          begin
            ostCnt_d = ostCnt_q + 11'h001;
          end
        end
      end
      ST_EXT:
      begin
        if (failDet)
        begin
          state_d = ST_FAIL;
        end
      end
      ST_FAIL:
      begin
        state_d = ST_FAIL;
      end
      ST_SLEEP:
      begin
        if (wakeUp)
        begin
          state_d = ST_START;
          ostCnt_d = 11'h000;
        end
      end
      default:
      begin
        state_d = ST_START;
        ostCnt_d = 11'h000;
      end
    endcase
    if (scsToggle)
    begin
      state_d = ST_START;
      ostCnt_d = 11'h000;
    end
    // Sleep aborts any start-up in progress, so timeout status stays clear
    if (sleepEnter)
    begin
      state_d = ST_SLEEP;
      ostCnt_d = 11'h000;
    end
  end

  always_comb
  begin
    divCnt_d = divCnt_q;
    if (lfFall)
    begin
      divCnt_d = (divCnt_q == DIV_LAST) ? 6'h00 : divCnt_q + 6'h01;
    end
    failLatch_d = failLatch_q;
    if (sampleTick)
    begin
      failLatch_d = 1'b0;
    end
    if (extFall)
    begin
      failLatch_d = 1'b1;
    end
  end

  always_comb
  begin
    scs_d = scs_q;
    freq_d = freq_q;
    tune_d = tune_q;
    cfg_d = cfg_q;
    ie_d = ie_q;
    flag_d = flag_q;
    if (wrCtrl)
    begin
      scs_d = pwdata[SCS_BIT];
      freq_d = pwdata[FREQ_LSB +: 3];
    end
    if (wrEn && (paddr == OSC_TUNE_ADDR))
    begin
      tune_d = pwdata[TUNE_LSB +: 5];
    end
    if (wrEn && (paddr == OSC_CFG_ADDR))
    begin
      cfg_d.mode = pwdata[CFG_MODE_LSB +: 3];
      cfg_d.twoSpeedEn = pwdata[CFG_TWO_SPEED_BIT];
      cfg_d.monEn = pwdata[CFG_MON_EN_BIT];
    end
    if (wrEn && (paddr == FAIL_IE_ADDR))
    begin
      ie_d = pwdata[FAIL_IE_BIT];
    end
    // Clearing is refused while the condition stands
    if (wrEn && (paddr == FAIL_FLAG_ADDR) && !pwdata[FAIL_FLAG_BIT] && (state_q != ST_FAIL))
    begin
      flag_d = 1'b0;
    end
    if (failDet)
    begin
      flag_d = 1'b1;
    end
  end

  // Mux control follows the next state so it lines up with state_q
  always_comb
  begin
    ctrl_d.runInternal = scs_d || (state_d != ST_EXT);
    ctrl_d.cpuHold = (state_d == ST_SLEEP)
      || ((state_d == ST_START) && !twoSpeed && !scs_d);
    ctrl_d.freqSel = freq_d;
    ctrl_d.tune = tune_d;
  end

  // Read data is captured in the setup cycle and shown in the access cycle
  always_comb
  begin
    rdData_d = rdData_q;
    if (psel && !penable)
    begin
      rdData_d = 32'h0000_0000;
      case (paddr)
        OSC_CTRL_ADDR: rdData_d[7:0] = ctrlRead;
        OSC_TUNE_ADDR: rdData_d[TUNE_LSB +: 5] = tune_q;
        OSC_CFG_ADDR: rdData_d[4:0] = {cfg_q.monEn, cfg_q.twoSpeedEn, cfg_q.mode};
        FAIL_FLAG_ADDR: rdData_d[7:0] = {flag_q, 6'h00, state_q == ST_FAIL};
        FAIL_IE_ADDR: rdData_d[FAIL_IE_BIT] = ie_q;
        default: rdData_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= ST_START;
      ostCnt_q <= 11'h000;
      divCnt_q <= 6'h00;
      failLatch_q <= 1'b0;
      extPrev_q <= 1'b0;
      lfPrev_q <= 1'b0;
      scs_q <= SCS_RST;
      freq_q <= FREQ_RST;
      tune_q <= TUNE_RST;
      cfg_q <= {CFG_MON_EN_RST, CFG_TWO_SPEED_RST, CFG_MODE_RST};
      flag_q <= 1'b0;
      ie_q <= FAIL_IE_RST;
      ctrl_q <= {1'b1, 1'b0, FREQ_RST, TUNE_RST};
      rdData_q <= 32'h0000_0000;
    end
    else
    begin
      state_q <= state_d;
      ostCnt_q <= ostCnt_d;
      divCnt_q <= divCnt_d;
      failLatch_q <= failLatch_d;
      extPrev_q <= extClk;
      lfPrev_q <= lfClk;
      scs_q <= scs_d;
      freq_q <= freq_d;
      tune_q <= tune_d;
      cfg_q <= cfg_d;
      flag_q <= flag_d;
      ie_q <= ie_d;
      ctrl_q <= ctrl_d;
      rdData_q <= rdData_d;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  sequence restartSeq;
    scsToggle && !sleepEnter ##1 (state_q == ST_START) && (ostCnt_q == 11'h000);
  endsequence

  sequence expirySeq;
    ostDone && !scsToggle && !sleepEnter ##1 (state_q == ST_EXT) && !failSafeActive;
  endsequence

  property restartP;
    (scsToggle && !sleepEnter) |-> restartSeq;
  endproperty

  property expiryP;
    (ostDone && !scsToggle && !sleepEnter) |-> expirySeq ##0 (clkCtrl.runInternal == scs_q);
  endproperty

  toggle_restart_a: assert property (restartP)
    else $error("select toggle did not restart start-up timer");
  sleep_clears_a: assert property (sleepEnter |=> (state_q == ST_SLEEP) && !failSafeActive
    && clkCtrl.cpuHold)
    else $error("sleep did not clear fail-safe");
  start_internal_a: assert property ((state_q == ST_START) |-> clkCtrl.runInternal
    && (clkCtrl.freqSel == freq_q))
    else $error("start-up not on selected internal clock");
  timer_expiry_a: assert property (expiryP)
    else $error("timer expiry did not switch to external");
  flag_hold_a: assert property ((state_q == ST_FAIL) && flag_q |=> flag_q)
    else $error("fail flag cleared while fail-safe active");
  no_early_fail_a: assert property ((state_q == ST_START) |=> (state_q != ST_FAIL))
    else $error("failure detected during start-up");
  skip_timer_a: assert property ((state_q == ST_START) && !crystal && !scsToggle
    && !sleepEnter |=> (state_q == ST_EXT) ##1 (state_q != ST_START))
    else $error("clock-input mode did not skip timer");
  two_speed_a: assert property ((state_q == ST_START) && cfg_q.monEn |-> !clkCtrl.cpuHold)
    else $error("monitor enabled without two-speed start-up");
  fail_switch_a: assert property ($rose(failSafeActive) |-> ($past(state_q) == ST_EXT)
    && flag_q && clkCtrl.runInternal && $past(lfFall))
    else $error("failure did not switch clock and set flag");
  ost_count_a: assert property ((state_q == ST_EXT) && ($past(state_q) == ST_START)
    && $past(crystal) && !$past(scsToggle) |-> ($past(ostCnt_q) == OST_LAST)
    && $past(extFall))
    else $error("start-up timer expired on wrong count");
  status_bit_a: assert property ((state_q == ST_FAIL) |-> !start_up_timeout_status && clkCtrl.runInternal)
    else $error("timeout status set while on internal clock");
endmodule // fail_safe_clock_control

`default_nettype wire

// ### bench/ext_osc_model.sv
// External crystal model that can run fast, run slow or stop dead
`timescale 1ns/1ps
`default_nettype none
module ext_osc_model (
  input wire logic core_clk, // Bench clock
  input wire logic run, // Oscillator running
  input wire logic slow, // Half period of three cycles
  output logic extClk // Oscillator output
);
  logic [1:0] halfCnt = 2'h0;
  initial extClk = 1'b0;
  // A dead crystal freezes at its last level, which the monitor must catch
  always @(posedge core_clk)
  begin
    if (run && (!slow || halfCnt == 2'h2))
    begin
      extClk <= !extClk;
      halfCnt <= 2'h0;
    end
    else if (run)
      halfCnt <= halfCnt + 2'h1;
  end
endmodule // ext_osc_model
`default_nettype wire

// ### bench/fail_safe_clock_control_tb.sv
// Self-checking bench for the fail-safe clock source control
`timescale 1ns/1ps
`default_nettype none
module fail_safe_clock_control_tb;
  import fail_safe_clock_pkg::*;
  logic core_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic sleepEnter = 1'b0, wakeUp = 1'b0, hfStable = 1'b1, lfStable = 1'b0;
  logic oscRun = 1'b1, oscSlow = 1'b1, lfClk = 1'b0, lfPhase = 1'b0;
  logic pready, pslverr, extClk, failSafeActive, oscFailIrq, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  clk_ctrl_s clkCtrl;
  int fails = 0, samplesChecked = 0, cycles = 0;

  fail_safe_clock_control i_dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .extClk(extClk), .lfClk(lfClk),
    .hfStable(hfStable), .lfStable(lfStable), .sleepEnter(sleepEnter), .wakeUp(wakeUp),
    .clkCtrl(clkCtrl), .failSafeActive(failSafeActive), .oscFailIrq(oscFailIrq));
  ext_osc_model i_osc (.core_clk(core_clk), .run(oscRun), .slow(oscSlow), .extClk(extClk));

  initial
  begin
    forever #4 core_clk = ~core_clk;
  end

  // Low oscillator sped up so a sample tick comes every 256 cycles
  always @(posedge core_clk)
  begin
    lfPhase <= !lfPhase;
    if (lfPhase)
      lfClk <= !lfClk;
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask

  function automatic logic [31:0] ctl(input logic [2:0] f, input logic o, input logic s);
    return {25'h0, f, o, hfStable, lfStable, s};
  endfunction

  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge core_clk);
  endtask

  // Bounded wait for the switch to the external source
  task automatic wait_ext(input int limit);
    for (int n = 0; n < limit && clkCtrl.runInternal !== 1'b0; n++)
      @(negedge core_clk);
    chk("runInternal", 32'h0, {31'h0, clkCtrl.runInternal});
  endtask

  task automatic wait_fail;
    for (int n = 0; n < 800 && failSafeActive !== 1'b1; n++)
      @(negedge core_clk);
    chk("failSafeActive", 32'h1, {31'h0, failSafeActive});
  endtask

  task automatic test_reset;
    chk("freqSel", 32'h6, {29'h0, clkCtrl.freqSel});
    xfer(OSC_CTRL_ADDR, 1'b0, 32'h0);
    chk("control", ctl(3'h6, 1'b0, 1'b0), rd);
    chk("cpuHold", 32'h1, {31'h0, clkCtrl.cpuHold});
    repeat (6000) @(negedge core_clk);
    chk("runInternal", 32'h1, {31'h0, clkCtrl.runInternal});
    wait_ext(200);
    xfer(OSC_CTRL_ADDR, 1'b0, 32'h0);
    chk("control", ctl(3'h6, 1'b1, 1'b0), rd);
    $display("done: reset and start-up");
  endtask

  task automatic test_fields;
    for (int f = 0; f < 8; f++)
    begin
      @(posedge core_clk);
      hfStable <= f[0];
      lfStable <= f[1];
      xfer(OSC_CTRL_ADDR, 1'b1, {25'h0, 3'(f), 4'h0});
      xfer(OSC_TUNE_ADDR, 1'b1, 32'(f));
      chk("tune", 32'(f), {27'h0, clkCtrl.tune});
      chk("freqSel", 32'(f), {29'h0, clkCtrl.freqSel});
      xfer(OSC_CTRL_ADDR, 1'b0, 32'h0);
      chk("control", ctl(3'(f), 1'b1, 1'b0), rd);
    end
    xfer(12'h000, 1'b0, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    chk("unmapped", 32'h0, rd);
    $display("done: register fields");
  endtask

  task automatic test_monitor;
    @(posedge core_clk);
    oscSlow <= 1'b0;
    xfer(OSC_CFG_ADDR, 1'b1, 32'h11);
    xfer(FAIL_IE_ADDR, 1'b1, 32'h80);
    xfer(OSC_CTRL_ADDR, 1'b1, 32'h71);
    chk("runInternal", 32'h1, {31'h0, clkCtrl.runInternal});
    xfer(OSC_CTRL_ADDR, 1'b1, 32'h70);
    chk("cpuHold", 32'h0, {31'h0, clkCtrl.cpuHold});
    chk("runInternal", 32'h1, {31'h0, clkCtrl.runInternal});
    xfer(OSC_CTRL_ADDR, 1'b0, 32'h0);
    chk("control", ctl(3'h7, 1'b0, 1'b0), rd);
    wait_ext(2200);
    $display("done: two-speed restart");
  endtask

  task automatic test_failure;
    @(posedge core_clk);
    oscRun <= 1'b0;
    wait_fail();
    chk("runInternal", 32'h1, {31'h0, clkCtrl.runInternal});
    chk("oscFailIrq", 32'h1, {31'h0, oscFailIrq});
    xfer(FAIL_FLAG_ADDR, 1'b1, 32'h0);
    xfer(FAIL_FLAG_ADDR, 1'b0, 32'h0);
    chk("failFlag", 32'h81, rd);
    xfer(OSC_CTRL_ADDR, 1'b1, 32'h71);
    chk("failSafeActive", 32'h0, {31'h0, failSafeActive});
    xfer(FAIL_FLAG_ADDR, 1'b1, 32'h0);
    xfer(FAIL_FLAG_ADDR, 1'b0, 32'h0);
    chk("failFlag", 32'h0, rd);
    chk("oscFailIrq", 32'h0, {31'h0, oscFailIrq});
    @(posedge core_clk);
    oscRun <= 1'b1;
    xfer(OSC_CTRL_ADDR, 1'b1, 32'h70);
    wait_ext(2200);
    $display("done: failure and recovery");
  endtask

  task automatic test_sleep;
    @(posedge core_clk);
    sleepEnter <= 1'b1;
    @(posedge core_clk);
    sleepEnter <= 1'b0;
    @(negedge core_clk);
    chk("cpuHold", 32'h1, {31'h0, clkCtrl.cpuHold});
    @(posedge core_clk);
    wakeUp <= 1'b1;
    oscRun <= 1'b0;
    @(posedge core_clk);
    wakeUp <= 1'b0;
    repeat (700) @(negedge core_clk);
    chk("failSafeActive", 32'h0, {31'h0, failSafeActive});
    @(posedge core_clk);
    oscRun <= 1'b1;
    wait_ext(2200);
    $display("done: sleep and wake");
  endtask

  task automatic test_ec;
    @(posedge core_clk);
    oscRun <= 1'b0;
    xfer(OSC_CFG_ADDR, 1'b1, 32'h13);
    xfer(OSC_CTRL_ADDR, 1'b1, 32'h71);
    xfer(OSC_CTRL_ADDR, 1'b1, 32'h70);
    wait_ext(2);
    wait_fail();
    @(posedge core_clk);
    rst_b <= 1'b0;
    @(negedge core_clk);
    chk("failSafeActive", 32'h0, {31'h0, failSafeActive});
    chk("freqSel", 32'h6, {29'h0, clkCtrl.freqSel});
    $display("done: clock input mode");
  endtask

  initial
  begin
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    @(negedge core_clk);
    test_reset();
    test_fields();
    test_monitor();
    test_failure();
    test_sleep();
    test_ec();
    tally_and_finish();
  end
endmodule // fail_safe_clock_control_tb
`default_nettype wire
